// [rtl/omc_ctrl.sv]
// Purpose: Low-speed control, rate select, loopback routing and ID bus slave
// Assumes: All pins asynchronous to clk; host pulls the open-drain lines up
// Notes:   Optical and electrical streams are modelled as 66-bit words
`timescale 1ns/1ps
module omc_ctrl #(
  parameter int         LOCK_CYCLES = omc_pkg::LOCK_CYC,
  parameter int         W           = omc_pkg::WORD_W,
  parameter int         DEPTH       = omc_pkg::FIFO_DEPTH,
  parameter logic [6:0] DEV_ADDR    = omc_pkg::ID_DEV_ADDR
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     rx_speed_select,
  input  wire logic                     tx_speed_select,
  input  wire logic                     tx_disable,
  input  wire logic                     laser_fault,
  input  wire logic                     rx_power_low,
  input  wire logic                     id_bus_clock_pin,
  input  wire logic                     id_bus_data_pin_in,
  output logic                          id_bus_data_pin_out,
  output logic                          id_bus_data_pin_oe_n,
  output logic                          presence_ground_out,
  output logic                          presence_ground_oe_n,
  output logic                          tx_fault_out,
  output logic                          tx_fault_oe_n,
  output logic                          received_signal_lost_out,
  output logic                          received_signal_lost_oe_n,
  input  wire logic                     rx_opt_valid,
  output logic                          rx_opt_ready,
  input  wire logic [W-1:0]             rx_opt_data,
  input  wire logic                     serial_tx_input_valid,
  output logic                          serial_tx_input_ready,
  input  wire logic [W-1:0]             serial_tx_input_data,
  output logic                          rx_elec_valid,
  input  wire logic                     rx_elec_ready,
  output logic [W-1:0]                  rx_elec_data,
  output logic                          laser_valid,
  output logic [W-1:0]                  laser_data,
  output logic                          laser_enable,
  output logic                          tx_high_rate_opt,
  output logic                          rx_cdr_engaged,
  output logic                          rx_cdr_locked,
  output logic [omc_pkg::SET_W-1:0]     tx_eq_setting,
  output logic [omc_pkg::SET_W-1:0]     rx_emphasis_setting
);
  import omc_pkg::*;

  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);

  // Readback mux for the diagnostic bytes
  function automatic logic [7:0] omc_rd_byte(input logic [7:0] a, input logic [7:0] sts,
                                             input logic [7:0] ctl, input logic [SET_W-1:0] eq,
                                             input logic [SET_W-1:0] emph);
    logic [7:0] r;
    r = 8'h00;
    if (a == REG_STATUS) r = sts;
    else if (a == REG_LOOP) r = ctl;
    else if (a == REG_EQ) r = {{(8-SET_W){1'b0}}, eq};
    else if (a == REG_EMPH) r = {{(8-SET_W){1'b0}}, emph};
    return r;
  endfunction : omc_rd_byte

  logic [PIN_N-1:0] s1_q;
  logic [PIN_N-1:0] s2_q;
  logic [PIN_N-1:0] s3_q;
  logic [PIN_N-1:0] f_q;
  logic             soft_dis_q;
  logic             oloop_q;
  logic             eloop_q;
  logic             pass_q;
  logic [SET_W-1:0] eq_q;
  logic [SET_W-1:0] emph_q;
  omc_i2c_e         st_q, st_d, after_q, after_d;
  logic [7:0]       sh_q, sh_d, ptr_q, ptr_d;
  logic [3:0]       cnt_q, cnt_d;
  logic             sda_oe_n_q, sda_oe_n_d;
  logic             wr_en;
  logic [7:0]       status_byte;
  logic [LOCK_W-1:0] lock_cnt_q;
  logic             locked_q;
  logic             laser_valid_q;
  logic [W-1:0]     laser_data_q;
  logic             laser_en_q;
  logic             tx_rate_q;
  logic             fifo_in_ready;

  // Pin synchronisers; a pin counts once stages two and three agree
  wire [PIN_N-1:0] pins = {rx_power_low, laser_fault, id_bus_data_pin_in, id_bus_clock_pin,
                           tx_disable, tx_speed_select, rx_speed_select};
  wire [PIN_N-1:0] agree = ~(s2_q ^ s3_q);
  wire [PIN_N-1:0] f_d   = (s2_q & agree) | (f_q & ~agree);

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
      s3_q <= PIN_RST;
      f_q  <= PIN_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  // Filtered pin levels
  wire rxsel  = f_q[PIN_RXSEL];
  wire txsel  = f_q[PIN_TXSEL];
  wire txdis  = f_q[PIN_TXDIS];
  wire fault  = f_q[PIN_FAULT];
  wire lowpwr = f_q[PIN_LOWPWR];

  // Bus conditions from filtered edges
  wire scl_rise  = f_d[PIN_SCL] & ~f_q[PIN_SCL];
  wire scl_fall  = ~f_d[PIN_SCL] & f_q[PIN_SCL];
  wire scl_hold  = f_d[PIN_SCL] & f_q[PIN_SCL];
  wire i2c_start = scl_hold & f_q[PIN_SDA] & ~f_d[PIN_SDA];
  wire i2c_stop  = scl_hold & ~f_q[PIN_SDA] & f_d[PIN_SDA];
  wire sda_now   = f_q[PIN_SDA];
  wire [7:0] ctl_byte = {5'h00, pass_q, eloop_q, oloop_q};
  wire [7:0] rd_byte  = omc_rd_byte(ptr_q, status_byte, ctl_byte, eq_q, emph_q);

  // Status byte built from filtered pin state and the software disable bit
  always_comb begin
    status_byte                   = 8'h00;
    status_byte[STS_PIN_DIS_BIT]  = txdis;
    status_byte[STS_SOFT_DIS_BIT] = soft_dis_q;
    status_byte[STS_FAULT_BIT]    = fault;
    status_byte[STS_LOS_BIT]      = lowpwr;
  end

  // Two-wire slave; data changes only while the clock line is low
  always_comb begin
    st_d       = st_q;
    after_d    = after_q;
    sh_d       = sh_q;
    ptr_d      = ptr_q;
    cnt_d      = cnt_q;
    sda_oe_n_d = sda_oe_n_q;
    wr_en      = 1'b0;
    if (i2c_stop) begin
      st_d       = S_IDLE;
      sda_oe_n_d = 1'b1;
    end else if (i2c_start) begin
      st_d       = S_ADDR;
      cnt_d      = 4'h0;
      sda_oe_n_d = 1'b1;
    end else if (scl_rise) begin
      case (st_q)
        S_ADDR, S_PTR, S_WR: begin
          sh_d  = {sh_q[6:0], sda_now};
          cnt_d = cnt_q + 4'h1;
        end
        S_RD: cnt_d = cnt_q + 4'h1;
        S_RACK: after_d = sda_now ? S_IDLE : S_RD; // Master nack ends the read
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        S_ADDR: begin
          if (cnt_q == BYTE_BITS) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              st_d       = S_ACK;
              sda_oe_n_d = 1'b0;
              after_d    = sh_q[0] ? S_RD : S_PTR;
            end else begin
              st_d = S_IDLE;
            end
          end
        end
        S_PTR: begin
          if (cnt_q == BYTE_BITS) begin
            ptr_d      = sh_q;
            st_d       = S_ACK;
            sda_oe_n_d = 1'b0;
            after_d    = S_WR;
          end
        end
        S_WR: begin
          if (cnt_q == BYTE_BITS) begin
            wr_en      = 1'b1;
            ptr_d      = ptr_q + 8'h01;
            st_d       = S_ACK;
            sda_oe_n_d = 1'b0;
            after_d    = S_WR;
          end
        end
        S_RD: begin
          if (cnt_q == BYTE_BITS) begin
            st_d       = S_RACK;
            sda_oe_n_d = 1'b1;
          end else begin
            sh_d       = {sh_q[6:0], 1'b0};
            sda_oe_n_d = sh_q[6];
          end
        end
        S_ACK, S_RACK: begin
          st_d       = after_q;
          cnt_d      = 4'h0;
          sda_oe_n_d = 1'b1;
          if (after_q == S_RD) begin
            sh_d       = rd_byte;
            ptr_d      = ptr_q + 8'h01;
            sda_oe_n_d = rd_byte[7];
          end
        end
        default: ;
      endcase
    end
  end

  // Slave state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q       <= S_IDLE;
      after_q    <= S_IDLE;
      sh_q       <= 8'h00;
      ptr_q      <= 8'h00;
      cnt_q      <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else begin
      st_q       <= st_d;
      after_q    <= after_d;
      sh_q       <= sh_d;
      ptr_q      <= ptr_d;
      cnt_q      <= cnt_d;
      sda_oe_n_q <= sda_oe_n_d;
    end
  end

  // Writable diagnostic bytes; settings take effect in place
  always_ff @(posedge clk) begin
    if (reset) begin
      soft_dis_q <= 1'b0;
      oloop_q    <= 1'b0;
      eloop_q    <= 1'b0;
      pass_q     <= 1'b0;
      eq_q       <= EQ_RESET;
      emph_q     <= EMPH_RESET;
    end else if (wr_en) begin
      if (ptr_q == REG_STATUS) begin
        soft_dis_q <= sh_q[STS_SOFT_DIS_BIT];
      end else if (ptr_q == REG_LOOP) begin
        oloop_q <= sh_q[CTL_OLOOP_BIT];
        eloop_q <= sh_q[CTL_ELOOP_BIT];
        pass_q  <= sh_q[CTL_PASS_BIT];
      end else if (ptr_q == REG_EQ) begin
        eq_q <= sh_q[SET_W-1:0];
      end else if (ptr_q == REG_EMPH) begin
        emph_q <= sh_q[SET_W-1:0];
      end
    end
  end

  // CDR is engaged by the receive select or by either loopback
  wire cdr_on = rxsel | oloop_q | eloop_q;
  wire [1:0] hdr = rx_opt_data[W-1:W-2];
  wire hdr_ok = (hdr == SYNC_HDR_DATA) || (hdr == SYNC_HDR_CTRL);
  wire rx_take = rx_opt_valid & rx_opt_ready;

  // Lock search; any bad sync header restarts it, and the count advances per accepted word, so slow traffic still locks
  always_ff @(posedge clk) begin
    if (reset || !cdr_on) begin
      lock_cnt_q <= '0;
      locked_q   <= 1'b0;
    end else if (rx_take) begin
      if (!hdr_ok) begin
        lock_cnt_q <= '0;
        locked_q   <= 1'b0;
      end else if (!locked_q) begin
        if (lock_cnt_q == LOCK_W'(LOCK_CYCLES - 1)) locked_q <= 1'b1;
        else lock_cnt_q <= lock_cnt_q + LOCK_W'(1);
      end
    end
  end

  // Routing; pass-through keeps the normal direction alive during a loop
  wire rx_pass   = cdr_on ? locked_q : 1'b1;
  wire rx_good   = rx_opt_valid & rx_pass;
  wire rd_on     = eloop_q | ~oloop_q | pass_q;
  wire opt_on    = oloop_q | ~eloop_q | pass_q;
  wire rx_to_rd  = ~eloop_q & rd_on;
  wire rx_to_opt = oloop_q & opt_on;
  wire tx_to_rd  = eloop_q;
  wire tx_to_opt = ~oloop_q & opt_on;
  wire tx_take   = serial_tx_input_valid & serial_tx_input_ready;
  wire fifo_in_valid        = tx_to_rd ? serial_tx_input_valid : (rx_to_rd & rx_good);
  wire [W-1:0] fifo_in_data = tx_to_rd ? serial_tx_input_data : rx_opt_data;

  // Unlocked words are dropped, so they never wait on the FIFO
  assign rx_opt_ready          = ~(rx_to_rd & rx_pass) | fifo_in_ready;
  assign serial_tx_input_ready = ~tx_to_rd | fifo_in_ready;

  omc_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (rx_elec_valid),
    .out_ready (rx_elec_ready),
    .out_data  (rx_elec_data)
  );

  // Laser side: data word, enable and rate optimisation
  always_ff @(posedge clk) begin
    if (reset) begin
      laser_valid_q <= 1'b0;
      laser_data_q  <= '0;
      laser_en_q    <= 1'b0;
      tx_rate_q     <= 1'b0;
    end else begin
      laser_valid_q <= (rx_to_opt & rx_good & rx_take) | (tx_to_opt & tx_take);
      laser_data_q  <= rx_to_opt ? rx_opt_data : serial_tx_input_data;
      laser_en_q    <= ~txdis & ~soft_dis_q & ~fault;
      tx_rate_q     <= txsel;
    end
  end

  assign laser_valid      = laser_valid_q;
  assign laser_data       = laser_data_q;
  assign laser_enable     = laser_en_q;
  assign tx_high_rate_opt = tx_rate_q;
  assign rx_cdr_engaged   = cdr_on;
  assign rx_cdr_locked    = locked_q;
  assign tx_eq_setting       = eq_q;
  assign rx_emphasis_setting = emph_q;

  // Open-drain lines: enable low while pulling low
  assign tx_fault_out              = 1'b0;
  assign tx_fault_oe_n             = fault;
  assign received_signal_lost_out  = 1'b0;
  assign received_signal_lost_oe_n = lowpwr;
  assign presence_ground_out       = 1'b0;
  assign presence_ground_oe_n      = 1'b0;
  assign id_bus_data_pin_out       = 1'b0;
  assign id_bus_data_pin_oe_n      = sda_oe_n_q;

  // Checks
  property p_hw_disable;
    @(posedge clk) disable iff (reset) txdis |=> !laser_enable;
  endproperty
  a_hw_disable: assert property (p_hw_disable) else $error("laser on while disable pin high");

  property p_soft_disable;
    @(posedge clk) disable iff (reset) soft_dis_q |=> !laser_enable;
  endproperty
  a_soft_disable: assert property (p_soft_disable) else $error("laser on with software disable");

  property p_fault;
    @(posedge clk) disable iff (reset) $rose(fault) |-> tx_fault_oe_n ##1 !laser_enable;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not released or laser still on");

  property p_presence;
    @(posedge clk) disable iff (reset) !presence_ground_oe_n && !presence_ground_out;
  endproperty
  a_presence: assert property (p_presence) else $error("presence pin not grounded");

  property p_los;
    @(posedge clk) disable iff (reset) received_signal_lost_oe_n == status_byte[STS_LOS_BIT];
  endproperty
  a_los: assert property (p_los) else $error("signal lost pin and status disagree");

  property p_fault_sts;
    @(posedge clk) disable iff (reset) $changed(fault) |-> status_byte[STS_FAULT_BIT] == tx_fault_oe_n;
  endproperty
  a_fault_sts: assert property (p_fault_sts) else $error("fault status bit wrong");

  property p_lock_time;
    @(posedge clk) disable iff (reset) $rose(rx_cdr_locked) |-> $past(lock_cnt_q) == LOCK_W'(LOCK_CYCLES - 1);
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock at wrong count");

  property p_bypass;
    @(posedge clk) disable iff (reset) !rxsel && !oloop_q && !eloop_q |=> !rx_cdr_locked;
  endproperty
  a_bypass: assert property (p_bypass) else $error("CDR locked while bypassed");

  property p_tx_rate;
    @(posedge clk) disable iff (reset) $changed(txsel) |=> tx_high_rate_opt == $past(txsel);
  endproperty
  a_tx_rate: assert property (p_tx_rate) else $error("transmit rate not followed");

  property p_reset_low;
    @(posedge clk) disable iff (reset) $past(reset) |-> !tx_high_rate_opt && !rx_cdr_engaged;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("rate selects not low after reset");

  property p_oloop;
    @(posedge clk) disable iff (reset)
      rx_to_opt && rx_good && rx_take |=> laser_valid && laser_data == $past(rx_opt_data);
  endproperty
  a_oloop: assert property (p_oloop) else $error("optical loopback word lost");

  property p_eloop;
    @(posedge clk) disable iff (reset) eloop_q && tx_take |-> fifo_in_valid && fifo_in_data == serial_tx_input_data;
  endproperty
  a_eloop: assert property (p_eloop) else $error("electrical loopback word lost");

  property p_pass;
    @(posedge clk) disable iff (reset) oloop_q && !eloop_q && !pass_q |-> !fifo_in_valid;
  endproperty
  a_pass: assert property (p_pass) else $error("received data forwarded without pass-through");

  property p_eq;
    @(posedge clk) disable iff (reset) wr_en && ptr_q == REG_EQ |=> tx_eq_setting == $past(sh_q[SET_W-1:0]);
  endproperty
  a_eq: assert property (p_eq) else $error("equalisation write lost");

  property p_emph;
    @(posedge clk) disable iff (reset) wr_en && ptr_q == REG_EMPH |=> rx_emphasis_setting == $past(sh_q[SET_W-1:0]);
  endproperty
  a_emph: assert property (p_emph) else $error("emphasis write lost");

endmodule : omc_ctrl

// [rtl/omc_fifo.sv]
// Purpose: Word FIFO between the receive data path and the electrical output
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty come from pointers with one extra wrap bit
`timescale 1ns/1ps
module omc_fifo #(
  parameter int W     = 66,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;

  // Pointer compare; wrap bit tells full from empty
  wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push  = in_valid && !full;
  wire pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[AW-1:0]];

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end

endmodule : omc_fifo

// [rtl/omc_pkg.sv]
// Purpose: Shared constants and types of the optical module control block
// Assumes: 25 MHz core clock, 66-bit words carry one 64b/66b block each
// Notes:   Diagnostic byte offsets are the two-wire bus pointer values
package omc_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOCK_TIME_NS  = 500000;                      // Longest CDR lock time
  localparam int LOCK_CYC      = LOCK_TIME_NS / CLK_PERIOD_NS; // Rounds down

  // Data path shape
  localparam int WORD_W     = 66;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] SYNC_HDR_DATA = 2'h1;
  localparam logic [1:0] SYNC_HDR_CTRL = 2'h2;

  // Two-wire slave
  localparam logic [6:0] ID_DEV_ADDR = 7'h51; // Arbitrary selection address
  localparam logic [3:0] BYTE_BITS   = 4'h8;

  // Diagnostic byte offsets
  localparam logic [7:0] REG_STATUS = 8'h6e;
  localparam logic [7:0] REG_LOOP   = 8'h6f;
  localparam logic [7:0] REG_EQ     = 8'h70;
  localparam logic [7:0] REG_EMPH   = 8'h71;

  // Field positions
  localparam int STS_PIN_DIS_BIT  = 7;
  localparam int STS_SOFT_DIS_BIT = 6;
  localparam int STS_FAULT_BIT    = 2;
  localparam int STS_LOS_BIT      = 1;
  localparam int CTL_OLOOP_BIT    = 0;
  localparam int CTL_ELOOP_BIT    = 1;
  localparam int CTL_PASS_BIT     = 2;
  localparam int SET_W            = 4;

  // Reset values
  localparam logic [SET_W-1:0] EQ_RESET   = 4'h0;
  localparam logic [SET_W-1:0] EMPH_RESET = 4'h0;

  // Synchronised pin vector
  localparam int PIN_RXSEL  = 0;
  localparam int PIN_TXSEL  = 1;
  localparam int PIN_TXDIS  = 2;
  localparam int PIN_SCL    = 3;
  localparam int PIN_SDA    = 4;
  localparam int PIN_FAULT  = 5;
  localparam int PIN_LOWPWR = 6;
  localparam int PIN_N      = 7;
  localparam logic [PIN_N-1:0] PIN_RST = 7'h5c; // Disable, bus lines, signal lost high

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PTR, S_WR, S_RD, S_ACK, S_RACK
  } omc_i2c_e;

endpackage : omc_pkg

// [test/omc_host.sv]
// Purpose: Host side model driving the two-wire management bus
// Assumes: Bus lines pulled up on the host board
// Notes:   Each SCL phase lasts 8 core clocks, well above the minimum
`timescale 1ns/1ps
module omc_host (
  input  wire logic clk,
  input  wire logic dev_oe_n,
  output logic      scl,
  output logic      sda
);
  logic sda_q = 1'b1;
  initial scl = 1'b1;
  // Wired-and of both parties against the pull-up
  assign sda = sda_q & dev_oe_n;
  task automatic ph();
    repeat (8) @(negedge clk);
  endtask : ph
  // Also serves as repeated start
  task automatic start();
    sda_q = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_q = 1'b0;
    ph();
    scl = 1'b0;
    ph();
  endtask : start
  task automatic stop();
    sda_q = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_q = 1'b1;
    ph();
  endtask : stop
  // Eight bits MSB first, then one ack bit driven as last
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic a);
    for (int i = 8; i >= 0; i--) begin
      sda_q = (i == 0) ? last : d[i-1];
      ph();
      scl = 1'b1;
      ph();
      if (i == 0) a = sda;
      else q[i-1] = sda;
      scl = 1'b0;
    end
    ph();
  endtask : xfer
endmodule : omc_host

// [test/tb_top.sv]
// Purpose: Self-checking bench for the optical module control block
// Assumes: Lock count shortened to 20 words
// Notes:   Queue scoreboard models routing, lock and the FIFO
`timescale 1ns/1ps
module tb_top;
  import omc_pkg::*;
  localparam int LK = 20;
  logic clk = 0, reset = 1, rsel = 0, tsel = 0, dis = 1, flt = 0, pwr = 0;
  logic rxv = 0, txv = 0, erdy = 0, scl, sda, oe_n, rrdy, trdy, ev, lv, len, thr, eng, lkd;
  logic pg, pg_n, tf_n, ls_n, tfo, lso, sdo;
  logic [65:0] rxd = 0, txd = 0, ed, ld;
  logic [3:0]  eqs, ems;
  logic [7:0]  ml = 0, q;
  logic [65:0] eq[$], lq[$];
  int miscompares = 0, comparisons = 0, cyc = 0, cnt = 0;
  bit lk = 0;
  always #20 clk = ~clk;
  omc_host omc_host_inst (.clk(clk), .dev_oe_n(oe_n), .scl(scl), .sda(sda));
  omc_ctrl #(.LOCK_CYCLES(LK)) omc_ctrl_inst (.clk(clk), .reset(reset), .rx_speed_select(rsel),
    .tx_speed_select(tsel), .tx_disable(dis), .laser_fault(flt), .rx_power_low(pwr),
    .id_bus_clock_pin(scl), .id_bus_data_pin_in(sda), .id_bus_data_pin_out(sdo), .id_bus_data_pin_oe_n(oe_n),
    .presence_ground_out(pg), .presence_ground_oe_n(pg_n), .tx_fault_out(tfo), .tx_fault_oe_n(tf_n),
    .received_signal_lost_out(lso), .received_signal_lost_oe_n(ls_n), .rx_opt_valid(rxv), .rx_opt_ready(rrdy),
    .rx_opt_data(rxd), .serial_tx_input_valid(txv), .serial_tx_input_ready(trdy), .serial_tx_input_data(txd),
    .rx_elec_valid(ev), .rx_elec_ready(erdy), .rx_elec_data(ed), .laser_valid(lv), .laser_data(ld),
    .laser_enable(len), .tx_high_rate_opt(thr), .rx_cdr_engaged(eng), .rx_cdr_locked(lkd),
    .tx_eq_setting(eqs), .rx_emphasis_setting(ems));
  task automatic chk(input string n, input logic [65:0] e, input logic [65:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic stop_test();
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Scoreboard at the edge that takes each word; avoids racing the ready change at the falling edge
  always @(posedge clk) begin
    if (!reset && ev === 1'b1 && erdy) chk("elec", eq.size() ? eq.pop_front() : 'x, ed);
    if (!reset && lv === 1'b1) chk("laser", lq.size() ? lq.pop_front() : 'x, ld);
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end
  // Routing and lock model per accepted word
  task automatic route(input bit tx, input logic [65:0] w);
    bit e;
    e = rsel | ml[0] | ml[1];
    if (tx && ml[1]) eq.push_back(w);
    if (tx && !ml[0] && (!ml[1] || ml[2])) lq.push_back(w);
    if (!tx && (!e || lk) && ml[0]) lq.push_back(w);
    if (!tx && (!e || lk) && !ml[1] && (!ml[0] || ml[2])) eq.push_back(w);
    if (!tx) cnt = (e && (w[65:64] == SYNC_HDR_DATA || w[65:64] == SYNC_HDR_CTRL)) ? cnt + 1 : 0;
    if (!tx) lk = (cnt >= LK);
  endtask : route
  task automatic snd(input bit tx, input int n, input logic [1:0] h);
    logic [65:0] w;
    for (int i = 0; i < n; i++) begin
      w = {h, $urandom, $urandom};
      if (tx) {txd, txv} = {w, 1'b1};
      else {rxd, rxv} = {w, 1'b1};
      while (!(tx ? trdy : rrdy)) @(negedge clk);
      route(tx, w);
      @(negedge clk);
    end
    if (tx) txv = 0;
    else rxv = 0;
    @(negedge clk); // Valid stays low for an edge between calls
  endtask : snd
  task automatic pre(input logic [7:0] p);
    logic a;
    omc_host_inst.start();
    omc_host_inst.xfer({ID_DEV_ADDR, 1'b0}, 1'b1, q, a);
    chk("ack", 0, a);
    omc_host_inst.xfer(p, 1'b1, q, a);
  endtask : pre
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic a;
    pre(p);
    omc_host_inst.xfer(d, 1'b1, q, a);
    omc_host_inst.stop();
    repeat (8) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] p);
    logic a;
    pre(p);
    omc_host_inst.start();
    omc_host_inst.xfer({ID_DEV_ADDR, 1'b1}, 1'b1, q, a);
    chk("ack", 0, a);
    omc_host_inst.xfer(8'hff, 1'b1, q, a);
    omc_host_inst.stop();
  endtask : rd
  initial begin
    logic [7:0] v;
    void'($urandom(59));
    repeat (4) @(negedge clk);
    reset = 0;
    repeat (8) @(negedge clk);
    chk("laser_en", 0, len);
    chk("presence", 0, {pg, pg_n});
    chk("od_out", 0, {tfo, lso, sdo});
    chk("rates", 0, {thr, eng});
    // Random pin patterns
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      {rsel, tsel, dis, flt, pwr} = v[4:0];
      repeat (6) @(negedge clk);
      chk("laser_en", !dis && !flt, len);
      chk("tx_rate", tsel, thr);
      chk("cdr_eng", rsel, eng);
      chk("fault_oe_n", flt, tf_n);
      chk("lost_oe_n", pwr, ls_n);
    end
    {rsel, dis, flt, pwr} = 0;
    repeat (6) @(negedge clk);
    // Fill the FIFO with the output stalled, then drain
    snd(0, FIFO_DEPTH, SYNC_HDR_DATA);
    rxv = 1;
    repeat (3) @(negedge clk);
    chk("full", 0, rrdy);
    rxv = 0;
    erdy = 1;
    repeat (40) @(negedge clk);
    chk("drained", 0, eq.size());
    // Lock, lose lock on a bad header, lock again
    rsel = 1;
    repeat (6) @(negedge clk);
    snd(0, LK + 3, SYNC_HDR_CTRL);
    chk("locked", 1, lkd);
    snd(0, 1, 2'h3);
    chk("unlocked", 0, lkd);
    snd(0, LK, SYNC_HDR_DATA);
    v = $urandom;
    wr(REG_EQ, {4'h0, v[3:0]});
    wr(REG_EMPH, {4'h0, v[7:4]});
    chk("eq", v[3:0], eqs);
    chk("emph", v[7:4], ems);
    wr(REG_STATUS, 8'h40);
    chk("laser_en", 0, len);
    {flt, pwr} = 2'b11;
    rd(REG_STATUS);
    chk("laser_en", 0, len);
    chk("status", 8'h46, q);
    {flt, pwr} = 2'b00;
    wr(REG_STATUS, 8'h00);
    chk("laser_en", 1, len);
    // Loopback modes and pass-through
    for (int k = 0; k < 5; k++) begin
      ml = (k == 0) ? 8'h01 : (k == 1) ? 8'h05 : (k == 2) ? 8'h02 : (k == 3) ? 8'h06 : 8'h03;
      wr(REG_LOOP, ml);
      snd(0, 3, SYNC_HDR_DATA);
      snd(1, 3, SYNC_HDR_DATA);
      repeat (30) @(negedge clk);
    end
    chk("left", 0, eq.size() + lq.size());
    stop_test();
  end
endmodule : tb_top
